// File: rtl/imrst_pkg.sv
/*
 * Shared constants of the word-level I2C transfer controller: register
 * addresses, field positions, reset values, bus timing counts and states.
 * Assumes a 25 MHz system clock; timing counts are derived from it.
 */
package imrst_pkg;

    // Register bus width and register addresses
    localparam int REG_AW = 3;
    localparam logic [REG_AW-1:0] ADDR_CONTROL_ONE = 3'h0;
    localparam logic [REG_AW-1:0] ADDR_CONTROL_TWO = 3'h1;
    localparam logic [REG_AW-1:0] ADDR_DATA_BUFFER = 3'h2;
    localparam logic [REG_AW-1:0] ADDR_OWN_ADDRESS = 3'h3;

    // control_one fields
    localparam int C1_BC_HI = 7;
    localparam int C1_BC_LO = 5;
    localparam int C1_ACK = 4;
    localparam int C1_NOMATCH = 3;

    // control_two (write) and status_two (read) fields
    localparam int C2_ROLE = 7;
    localparam int C2_TRX = 6;
    localparam int C2_BUSY = 5;
    localparam int C2_PEND = 4;
    localparam int S2_AL = 3;
    localparam int S2_AAS = 2;
    localparam int S2_AD0 = 1;
    localparam int S2_LRB = 0;

    // Reset values
    localparam logic [7:0] CONTROL_ONE_RST = 8'h10;
    localparam logic [6:0] OWN_ADDRESS_RST = 7'h00;

    // Bus byte values and word sizes
    localparam logic [7:0] GENERAL_CALL = 8'h00;
    localparam logic [3:0] WORD_BITS_FULL = 4'h8;

    // Clock-line timing: times in ns, counts in system clocks (rounded up)
    localparam int CLK_MHZ = 25;
    localparam int SCL_LOW_NS = 640;
    localparam int SCL_HIGH_NS = 480;
    localparam logic [7:0] SCL_LOW_CYC = 8'((SCL_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] SCL_HIGH_CYC = 8'((SCL_HIGH_NS * CLK_MHZ + 999) / 1000);

    // Word engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_HOLD = 2'b10
    } imrst_state_t;

endpackage : imrst_pkg

// File: rtl/imrst_line_if.sv
/*
 * Carrier for the conditioned bus-line events between the line sensor and
 * the transfer controller. Both ends run on the system clock.
 */
`timescale 1ns/10ps
interface imrst_line_if;
    logic scl_rise;
    logic scl_fall;
    logic sda_level;
    logic start_det;
    logic stop_det;

    modport producer (output scl_rise, output scl_fall, output sda_level, output start_det, output stop_det);
    modport consumer (input scl_rise, input scl_fall, input sda_level, input start_det, input stop_det);
endinterface : imrst_line_if

// File: rtl/imrst_line_sense.sv
/*
 * Synchronises the clock and data lines with three flip-flops each and
 * derives clock edges, start and stop conditions as one-cycle pulses.
 * Assumes both lines idle high and are asynchronous to i_clk.
 */
`timescale 1ns/10ps
module imrst_line_sense (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Raw bus lines
    input wire logic i_scl,
    input wire logic i_sda,
    // Conditioned events
    imrst_line_if.producer line
);
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_filt;
    logic sda_filt;
    logic next_scl;
    logic next_sda;

    // Three-stage synchronisers; a level is accepted once stages two and three agree
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_filt <= 1'b1;
            sda_filt <= 1'b1;
        end else if (i_ce) begin
            scl_sync <= {scl_sync[1:0], i_scl};
            sda_sync <= {sda_sync[1:0], i_sda};
            scl_filt <= next_scl;
            sda_filt <= next_sda;
        end
    end

    // Accepted levels for this cycle
    assign next_scl = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_filt;
    assign next_sda = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_filt;

    // Edge and condition pulses, frozen with the clock enable
    assign line.scl_rise = i_ce && next_scl && !scl_filt;
    assign line.scl_fall = i_ce && !next_scl && scl_filt;
    assign line.sda_level = sda_filt;
    assign line.start_det = i_ce && scl_filt && next_scl && sda_filt && !next_sda;
    assign line.stop_det = i_ce && scl_filt && next_scl && !sda_filt && next_sda;

endmodule : imrst_line_sense

// File: rtl/imrst_top.sv
/*
 * Word-level I2C transfer controller: master data phase with receive
 * termination by negative acknowledge, slave address recognition, slave
 * receive and transmit, arbitration loss, and the status flags software
 * uses to service each word. Registers sit on a plain strobe port.
 * Assumes start, stop and restart generation are driven elsewhere and
 * that the lines are open-drain, resolved outside from the enables.
 */
`timescale 1ns/10ps

// Behaviour
// - Master receive: dummy buffer write sets pending, clocks next word, acks low.
// - Buffer read right after the address phase returns the received address byte.
// - Each word interrupt clears pending, holds clock low; resume releases after low time.
// - Ack off with bit count 000: one 8-bit word without acknowledge clock.
// - Ack off with bit count 001: single bit, data line released, a negative ack.
// - Slave with matching enabled interrupts after ack when own address received.
// - Slave with matching enabled interrupts after ack on a general call.
// - Once addressed, the slave interrupts at the end of every word.
// - Arbitration loss drops to slave, interrupts at word end, clears pending.
// - Lost during address to own read address: direction, lost, matched set.
// - After transmit word, software checks last bit to release or continue.
// - Slave transmit word end: direction set, lost, matched, general call clear.
// - Addressed for write or general call, buffer write or pending set resumes.
// - Lost while not addressed: only lost flag set at the word end.
// - Own address zero matches start byte 0x01 and sets direction.
// - Word interrupt at the falling edge of the word's last clock (ninth for 8 bits plus ack), clearing pending there.
// - General call flag clears on any start or stop condition.
module imrst_top #(
    parameter logic [7:0] P_LOW_CYC = imrst_pkg::SCL_LOW_CYC,
    parameter logic [7:0] P_HIGH_CYC = imrst_pkg::SCL_HIGH_CYC
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Register port
    input wire logic [imrst_pkg::REG_AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Clock line
    input wire logic i_clock_line_io,
    output logic o_clock_line_io,
    output logic o_clock_line_io_oe,
    // Data line
    input wire logic i_data_line_io,
    output logic o_data_line_io,
    output logic o_data_line_io_oe,
    // Word event
    output logic o_transfer_irq
);
    import imrst_pkg::*;

    imrst_line_if lines ();

    imrst_line_sense u_sense (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_scl(i_clock_line_io),
        .i_sda(i_data_line_io),
        .line(lines.producer)
    );

    // Words of 1 to 8 bits; a count of zero means eight
    function automatic logic [3:0] word_len(input logic [2:0] bc);
        word_len = (bc == 3'h0) ? WORD_BITS_FULL : {1'b0, bc};
    endfunction : word_len

    // Software settings
    logic [2:0] bit_count;
    logic ack_en;
    logic address_match_disable;
    logic [6:0] own_address;
    // Status
    logic controller_role;
    logic transmit_direction;
    logic bus_busy;
    logic service_pending;
    logic lost_arbitration;
    logic address_matched;
    logic general_call_seen;
    logic last_received_bit;
    // Word engine
    imrst_state_t state;
    logic [3:0] bit_idx;
    logic first_word;
    logic addressed;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic sda_low;
    logic scl_low;
    logic [7:0] tmr;
    logic phase_hi;

    // Register strobes
    logic wr_c1;
    logic wr_c2;
    logic wr_dbuf;
    logic rd_dbuf;
    logic wr_own;
    logic pend_set;
    assign wr_c1 = i_wr && (i_addr == ADDR_CONTROL_ONE);
    assign wr_c2 = i_wr && (i_addr == ADDR_CONTROL_TWO);
    assign wr_dbuf = i_wr && (i_addr == ADDR_DATA_BUFFER);
    assign rd_dbuf = i_rd && (i_addr == ADDR_DATA_BUFFER);
    assign wr_own = i_wr && (i_addr == ADDR_OWN_ADDRESS);
    assign pend_set = wr_c2 && i_wdata[C2_PEND];

    // Word shape and bus events seen by the engine
    logic resume;
    logic [3:0] data_bits;
    logic has_ack;
    logic [3:0] total_bits;
    logic rise_ev;
    logic fall_ev;
    logic ack_fall;
    logic word_done;
    logic gc_hit;
    logic own_hit;
    logic match_now;
    logic lose_ev;
    logic irq_ev;
    logic master_run;
    logic first_tx_bit;
    logic next_drive;

    assign resume = (state == ST_HOLD) && (wr_dbuf || pend_set);
    assign data_bits = first_word ? WORD_BITS_FULL : word_len(bit_count);
    assign has_ack = first_word || ack_en;
    assign total_bits = data_bits + {3'h0, has_ack};
    assign rise_ev = lines.scl_rise && (state == ST_ACTIVE);
    assign fall_ev = lines.scl_fall && (state == ST_ACTIVE);
    assign ack_fall = fall_ev && has_ack && (bit_idx == data_bits);
    assign word_done = fall_ev && (bit_idx == total_bits);
    assign gc_hit = rx_shift == GENERAL_CALL;
    assign own_hit = rx_shift[7:1] == own_address;
    assign match_now = first_word && !controller_role && !address_match_disable && (gc_hit || own_hit);
    assign lose_ev = rise_ev && controller_role && transmit_direction && (bit_idx < data_bits)
                     && !sda_low && !lines.sda_level;
    assign irq_ev = word_done && (controller_role || addressed || lost_arbitration);
    assign master_run = controller_role && service_pending && (state == ST_ACTIVE);
    assign first_tx_bit = wr_dbuf ? i_wdata[7] : tx_shift[7];

    // Drive for the slot that the next clock pulse carries
    always_comb begin
        next_drive = 1'b0;
        if (bit_idx < data_bits) begin
            next_drive = transmit_direction && !tx_shift[7];
        end else if (has_ack && (bit_idx == data_bits)) begin
            // Receiver acknowledges; with ack clocking off the line stays high
            next_drive = !transmit_direction && (first_word ? match_now : ack_en);
        end
    end

    // Register writes to the settings
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bit_count <= CONTROL_ONE_RST[C1_BC_HI:C1_BC_LO];
            ack_en <= CONTROL_ONE_RST[C1_ACK];
            address_match_disable <= CONTROL_ONE_RST[C1_NOMATCH];
            own_address <= OWN_ADDRESS_RST;
        end else if (i_ce) begin
            if (wr_c1) begin
                bit_count <= i_wdata[C1_BC_HI:C1_BC_LO];
                ack_en <= i_wdata[C1_ACK];
                address_match_disable <= i_wdata[C1_NOMATCH];
            end
            if (wr_own) begin
                own_address <= i_wdata[7:1];
            end
        end
    end

    // Role and direction: software writes, hardware updates after
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            controller_role <= 1'b0;
            transmit_direction <= 1'b0;
        end else if (i_ce) begin
            if (wr_c2) begin
                controller_role <= i_wdata[C2_ROLE];
                transmit_direction <= i_wdata[C2_TRX];
            end
            if (lose_ev) begin
                controller_role <= 1'b0;
                transmit_direction <= 1'b0;
            end
            if (word_done && first_word) begin
                if (addressed) begin
                    transmit_direction <= rx_shift[0];
                end else if (controller_role && !last_received_bit) begin
                    transmit_direction <= !rx_shift[0];
                end
            end
        end
    end

    // Service pending: set by buffer write or explicit set, cleared by the word interrupt
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            service_pending <= 1'b0;
        end else if (i_ce) begin
            if (wr_dbuf || pend_set) begin
                service_pending <= 1'b1;
            end
            if (irq_ev) begin
                service_pending <= 1'b0;
            end
        end
    end

    // Arbitration, address and general call flags; hardware sets win over clears
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            lost_arbitration <= 1'b0;
            address_matched <= 1'b0;
            general_call_seen <= 1'b0;
            addressed <= 1'b0;
        end else if (i_ce) begin
            if (wr_dbuf || rd_dbuf || wr_c2) begin
                lost_arbitration <= 1'b0;
            end
            if (wr_dbuf || rd_dbuf) begin
                address_matched <= 1'b0;
            end
            if (lines.start_det || lines.stop_det) begin
                general_call_seen <= 1'b0;
                addressed <= 1'b0;
            end
            if (lose_ev) begin
                lost_arbitration <= 1'b1;
            end
            if (ack_fall && match_now) begin
                address_matched <= 1'b1;
                general_call_seen <= gc_hit;
                addressed <= 1'b1;
            end
        end
    end

    // Bus busy and last received bit
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus_busy <= 1'b0;
            last_received_bit <= 1'b0;
        end else if (i_ce) begin
            if (lines.start_det) begin
                bus_busy <= 1'b1;
            end else if (lines.stop_det) begin
                bus_busy <= 1'b0;
            end
            if (rise_ev) begin
                last_received_bit <= lines.sda_level;
            end
        end
    end

    // Shift registers; the receive word holds the address byte after the address phase
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
        end else if (i_ce) begin
            if (rise_ev && (bit_idx < data_bits)) begin
                rx_shift <= {rx_shift[6:0], lines.sda_level};
                tx_shift <= {tx_shift[6:0], 1'b1};
            end
            if (wr_dbuf) begin
                tx_shift <= i_wdata;
            end
        end
    end

    // Word sequencing
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            bit_idx <= 4'h0;
            first_word <= 1'b0;
        end else if (i_ce) begin
            if (lines.stop_det) begin
                state <= ST_IDLE;
                bit_idx <= 4'h0;
            end else if (lines.start_det) begin
                state <= ST_ACTIVE;
                bit_idx <= 4'h0;
                first_word <= 1'b1;
            end else if (word_done) begin
                state <= irq_ev ? ST_HOLD : ST_IDLE;
                bit_idx <= 4'h0;
                first_word <= 1'b0;
            end else if (rise_ev) begin
                bit_idx <= bit_idx + 4'h1;
            end else if (resume) begin
                state <= (controller_role || addressed) ? ST_ACTIVE : ST_IDLE;
                bit_idx <= 4'h0;
            end
        end
    end

    // Data line drive: own data bits, acknowledge slot, released on loss
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sda_low <= 1'b0;
        end else if (i_ce) begin
            if (lines.stop_det || lose_ev || word_done) begin
                sda_low <= 1'b0;
            end else if (lines.start_det) begin
                sda_low <= controller_role && !tx_shift[7];
            end else if (fall_ev) begin
                sda_low <= next_drive;
            end else if (resume) begin
                sda_low <= (controller_role || addressed) && transmit_direction && !first_tx_bit;
            end
        end
    end

    // Clock line: held low after each interrupt, released after the low time, master pulses
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            scl_low <= 1'b0;
            tmr <= 8'h00;
            phase_hi <= 1'b0;
        end else if (i_ce) begin
            if (lines.stop_det) begin
                scl_low <= 1'b0;
                tmr <= 8'h00;
                phase_hi <= 1'b0;
            end else if (irq_ev) begin
                scl_low <= 1'b1;
                tmr <= 8'h00;
                phase_hi <= 1'b0;
            end else if (resume) begin
                tmr <= P_LOW_CYC;
                phase_hi <= 1'b0;
            end else if (lines.start_det && controller_role) begin
                tmr <= P_HIGH_CYC;
                phase_hi <= 1'b1;
            end else if (tmr != 8'h00) begin
                tmr <= tmr - 8'h01;
                if (tmr == 8'h01) begin
                    if (!phase_hi) begin
                        scl_low <= 1'b0;
                    end else if (master_run) begin
                        scl_low <= 1'b1;
                        tmr <= P_LOW_CYC;
                    end
                    phase_hi <= 1'b0;
                end
            end else if (master_run && lines.scl_rise) begin
                tmr <= P_HIGH_CYC;
                phase_hi <= 1'b1;
            end
        end
    end

    // Outputs: line enables, constant low drive levels, interrupt pulse
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_clock_line_io <= 1'b0;
            o_clock_line_io_oe <= 1'b0;
            o_data_line_io <= 1'b0;
            o_data_line_io_oe <= 1'b0;
            o_transfer_irq <= 1'b0;
        end else if (i_ce) begin
            o_clock_line_io <= 1'b0;
            o_clock_line_io_oe <= scl_low || irq_ev;
            o_data_line_io <= 1'b0;
            o_data_line_io_oe <= sda_low;
            o_transfer_irq <= irq_ev;
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= 8'h00;
            if (i_rd) begin
                unique case (i_addr)
                    ADDR_CONTROL_ONE: o_rdata <= {bit_count, ack_en, address_match_disable, 3'h0};
                    ADDR_CONTROL_TWO: o_rdata <= {controller_role, transmit_direction, bus_busy, service_pending,
                                                  lost_arbitration, address_matched, general_call_seen,
                                                  last_received_bit};
                    ADDR_DATA_BUFFER: o_rdata <= rx_shift;
                    ADDR_OWN_ADDRESS: o_rdata <= {own_address, 1'b0};
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule : imrst_top

// File: verif/imrst_checker_assertions.sv
/*
 * Port checker for imrst_top: word-end pulse, clock-line hold and release, read port.
 * Assumes one clock domain with synchronous active-high reset; attached by bind.
 */
`timescale 1ns/10ps
module imrst_checker
    import imrst_pkg::*;
#(
    parameter logic [7:0] P_LOW_CYC = SCL_LOW_CYC,
    parameter logic [7:0] P_HIGH_CYC = SCL_HIGH_CYC
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Register port
    input wire logic [imrst_pkg::REG_AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Lines
    input wire logic i_clock_line_io,
    input wire logic o_clock_line_io,
    input wire logic o_clock_line_io_oe,
    input wire logic i_data_line_io,
    input wire logic o_data_line_io,
    input wire logic o_data_line_io_oe,
    // Word event
    input wire logic o_transfer_irq
);
    localparam int LOW_SPAN = int'(P_LOW_CYC) + 3;
    logic resume_wr;
    logic armed;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Software resume request
    assign resume_wr = i_wr && (i_addr == ADDR_DATA_BUFFER || (i_addr == ADDR_CONTROL_TWO && i_wdata[C2_PEND]));

    // Remembers a resume until the hold ends
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            armed <= 1'b0;
        end else if (resume_wr) begin
            armed <= 1'b1;
        end else if (!o_clock_line_io_oe) begin
            armed <= 1'b0;
        end
    end

    sequence s_resume;
        o_clock_line_io_oe && resume_wr;
    endsequence
    sequence s_release;
        o_clock_line_io_oe ##[1:LOW_SPAN] !o_clock_line_io_oe;
    endsequence

    property p_irq_pulse; o_transfer_irq |=> !o_transfer_irq; endproperty
    property p_irq_holds; o_transfer_irq |-> o_clock_line_io_oe; endproperty
    property p_irq_after_fall;
        o_transfer_irq |-> !i_clock_line_io && !$past(i_clock_line_io) && !$past(i_clock_line_io, 2);
    endproperty
    property p_resume; s_resume |=> s_release; endproperty
    property p_hold_until_resume; $fell(o_clock_line_io_oe) |-> armed; endproperty
    property p_data_released; o_transfer_irq |=> !o_data_line_io_oe; endproperty
    property p_rdata_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    property p_open_drain; !o_clock_line_io && !o_data_line_io; endproperty

    a_irq_pulse: assert property (p_irq_pulse) else $error("word pulse too long");
    a_irq_holds: assert property (p_irq_holds) else $error("clock not held at word end");
    a_irq_after_fall: assert property (p_irq_after_fall) else $error("word end not after clock fall");
    a_resume: assert property (p_resume) else $error("clock not released after resume");
    a_hold_until_resume: assert property (p_hold_until_resume) else $error("clock released unasked");
    a_data_released: assert property (p_data_released) else $error("data line kept low");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
endmodule : imrst_checker

bind imrst_top imrst_checker #(.P_LOW_CYC(P_LOW_CYC), .P_HIGH_CYC(P_HIGH_CYC)) u_checker (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_clock_line_io(i_clock_line_io),
    .o_clock_line_io(o_clock_line_io), .o_clock_line_io_oe(o_clock_line_io_oe),
    .i_data_line_io(i_data_line_io), .o_data_line_io(o_data_line_io),
    .o_data_line_io_oe(o_data_line_io_oe), .o_transfer_irq(o_transfer_irq));

// File: verif/imrst_far_master.sv
/*
 * Behavioural bus controller on the far side of the serial lines, 320 ns bit period.
 * Assumes open-drain lines resolved by the bench with pull-ups.
 */
`timescale 1ns/10ps
module imrst_far_master (
    // Resolved lines
    input wire logic i_scl,
    input wire logic i_sda,
    // Pull-down requests
    output logic o_scl_low,
    output logic o_sda_low
);
    // Lines released at start
    initial {o_scl_low, o_sda_low} = 2'b00;

    // One bit slot: data set while low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        o_sda_low = !b;
        #160;
        o_scl_low = 1'b0;
        wait (i_scl === 1'b1);
        #50;
        r = i_sda;
        #50;
        o_scl_low = 1'b1;
        #60;
    endtask : bit_io

    // Word of eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_bit, ack);
    endtask : xfer

    task automatic send_start();
        o_sda_low = 1'b1;
        #200;
        o_scl_low = 1'b1;
        #40;
    endtask : send_start

    task automatic send_stop();
        o_sda_low = 1'b1;
        #160;
        o_scl_low = 1'b0;
        wait (i_scl === 1'b1);
        #120;
        o_sda_low = 1'b0;
        #400;
    endtask : send_stop
endmodule : imrst_far_master

// File: verif/tb_top.sv
/*
 * Self-checking bench for imrst_top in slave roles against a far-side controller.
 * Assumes the register map of imrst_pkg and a 25 MHz clock.
 */
`timescale 1ns/10ps
module tb_top;
    import imrst_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [REG_AW-1:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0, i_ce = 1'b1;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic scl_oe, sda_oe, scl_val, sda_val, irq, m_scl_low, m_sda_low;
    wire logic scl = !(scl_oe || m_scl_low);
    wire logic sda = !(sda_oe || m_sda_low);
    int failures = 0;
    int samples_checked = 0;
    int irq_n = 0, irq_base = 0;

    imrst_top #(.P_LOW_CYC(8'h04), .P_HIGH_CYC(8'h03)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_clock_line_io(scl), .o_clock_line_io(scl_val),
        .o_clock_line_io_oe(scl_oe), .i_data_line_io(sda), .o_data_line_io(sda_val),
        .o_data_line_io_oe(sda_oe), .o_transfer_irq(irq));
    imrst_far_master far (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));

    // Clock and word-end counter
    initial forever #20 i_clk = ~i_clk;
    always @(posedge i_clk) if (irq === 1'b1) irq_n++;

    task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Lets the line synchroniser and word-end logic land, then counts new word ends
    task automatic chk_irq(input int n);
        repeat (10) @(posedge i_clk);
        chk(8'(irq_n - irq_base), 8'(n));
        irq_base = irq_n;
    endtask : chk_irq

    // Start plus address word, then acknowledge, word end and masked status
    task automatic addr_word(input logic [7:0] b, input logic ack_e, input int n, input logic [7:0] m,
                             input logic [7:0] st_e);
        logic [7:0] q, st;
        logic ack;
        far.send_start();
        far.xfer(b, 1'b1, q, ack);
        chk({7'h00, ack}, {7'h00, ack_e});
        chk_irq(n);
        rd(ADDR_CONTROL_TWO, st);
        chk(st & m, st_e);
    endtask : addr_word

    task automatic tally_and_finish();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog
    initial begin
        #500000;
        failures++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] v, q;
        logic ack;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(ADDR_CONTROL_ONE, v);
        chk(v, CONTROL_ONE_RST);
        rd(3'h7, v);
        chk(v, 8'h00);
        @(posedge i_clk) i_ce <= 1'b0;
        wr(ADDR_OWN_ADDRESS, 8'h5A);
        i_ce <= 1'b1;
        rd(ADDR_OWN_ADDRESS, v);
        chk(v, 8'h00);
        $display("test reset done");
        wr(ADDR_OWN_ADDRESS, 8'hA0);
        addr_word(8'hA0, 1'b0, 1, 8'h7E, 8'h24);
        wr(ADDR_DATA_BUFFER, 8'hFF);
        far.xfer(8'h3C, 1'b1, q, ack);
        chk({7'h00, ack}, 8'h00);
        chk_irq(1);
        rd(ADDR_DATA_BUFFER, v);
        chk(v, 8'h3C);
        wr(ADDR_CONTROL_TWO, 8'h10);
        far.send_stop();
        $display("test slave receive done");
        addr_word(8'h00, 1'b0, 1, 8'h4E, 8'h06);
        wr(ADDR_DATA_BUFFER, 8'h00);
        far.send_stop();
        rd(ADDR_CONTROL_TWO, v);
        chk(v & 8'h02, 8'h00);
        $display("test general call done");
        addr_word(8'hB0, 1'b1, 0, 8'h04, 8'h00);
        far.send_stop();
        wr(ADDR_CONTROL_ONE, 8'h18);
        addr_word(8'hA0, 1'b1, 0, 8'h04, 8'h00);
        far.send_stop();
        wr(ADDR_CONTROL_ONE, 8'h10);
        $display("test refusals done");
        addr_word(8'hA1, 1'b0, 1, 8'h4E, 8'h44);
        wr(ADDR_DATA_BUFFER, 8'hC3);
        far.xfer(8'hFF, 1'b1, q, ack);
        chk(q, 8'hC3);
        chk_irq(1);
        rd(ADDR_CONTROL_TWO, v);
        chk(v & 8'h4F, 8'h41);
        wr(ADDR_CONTROL_TWO, 8'h10);
        far.send_stop();
        $display("test slave transmit done");
        wr(ADDR_OWN_ADDRESS, 8'h00);
        addr_word(8'h01, 1'b0, 1, 8'h40, 8'h40);
        wr(ADDR_CONTROL_TWO, 8'h10);
        far.send_stop();
        $display("test zero address done");
        tally_and_finish();
    end
endmodule : tb_top
